// ===== rtl/cfs_fault_supervisor.sv
// fault supervision and telemetry of the buck converter controller
`timescale 1ns/1ps
`include "cfs_map.svh"
module cfs_fault_supervisor #(
	parameter int MS_CYC     = `CFS_MS_CYC,
	parameter int SS_TIME_MS = `CFS_SS_TIME_MS
) (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        ce,
	input  wire logic        cycleStart,
	input  wire logic        pwmHigh,
	input  wire logic        pwmLow,
	input  wire logic        curSampleValid,
	input  wire logic [15:0] curSample,
	input  wire logic [7:0]  intTemp,
	input  wire logic [15:0] extTempRaw,
	input  wire logic        hsPeakPin,
	input  wire logic        ovPin,
	input  wire logic        uvPin,
	input  wire logic        extShortPin,
	input  wire logic        restartPin,
	input  wire logic [7:0]  regAddr,
	input  wire logic [15:0] regWrData,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic      [15:0] regRdData,
	output logic             hsGateOn,
	output logic             lsGateOn,
	output logic             powerGoodOut,
	output logic             alertOut,
	output logic             softStartOut
);
	localparam logic [15:0] HICCUP_MS = 16'(`CFS_HICCUP_PERIODS * SS_TIME_MS);
	localparam logic [16:0] MS_LAST   = 17'(MS_CYC - 1);

	cfs_pkg::cfs_main_t s_ff;
	cfs_pkg::cfs_main_t nxt_s;
	logic [15:0]        calCur;
	logic [15:0]        curAvg;
	logic               ssDis;
	logic               running;
	logic               intHot;
	logic               intCool;
	logic               extFault;
	logic               extWarn;
	logic               extCool;
	logic               ocEvt;
	logic               ocAny;
	logic               ocTrip;
	logic               ovTrip;
	logic               uvTrip;
	logic               tonTrip;
	logic               anyFault;
	logic [1:0]         ocResp;
	logic [1:0]         otResp;
	logic [1:0]         ovResp;
	logic [1:0]         uvResp;
	logic [6:0]         alertSrc;
	logic [15:0]        clrMask;

	// ****************************************
	// response decode
	// ****************************************
	function automatic cfs_pkg::cfs_state_t react(
		input logic [1:0]         resp,
		input cfs_pkg::cfs_state_t retry,
		input cfs_pkg::cfs_state_t cur
	);
		if (resp == `CFS_RESP_IGNORE) begin
			return cur;
		end else if (resp == `CFS_RESP_LATCH) begin
			return cfs_pkg::ST_LATCH;
		end else begin
			return retry;
		end
	endfunction

	function automatic logic sgt(input logic [15:0] a, input logic [15:0] b);
		return $signed(a) > $signed(b);
	endfunction

	// ****************************************
	// current path
	// ****************************************
	assign calCur = curSample + s_ff.calOffset; // see RULE2

	cfs_avg_filter u_avg (
		.clk        (clk),
		.reset      (reset),
		.ce         (ce),
		.sampleValid(curSampleValid),
		.sample     (calCur),
		.average    (curAvg)
	);

	// ****************************************
	// fault detection
	// ****************************************
	assign ocResp   = s_ff.respCfg[`CFS_RESP_OC_LSB +: 2];
	assign otResp   = s_ff.respCfg[`CFS_RESP_OT_LSB +: 2];
	assign ovResp   = s_ff.respCfg[`CFS_RESP_OV_LSB +: 2];
	assign uvResp   = s_ff.respCfg[`CFS_RESP_UV_LSB +: 2];
	assign ssDis    = s_ff.options[`CFS_OPT_SSDIS_BIT];
	assign running  = s_ff.state == cfs_pkg::ST_START || s_ff.state == cfs_pkg::ST_RUN;
	assign intHot   = intTemp > `CFS_TSD_DEGC;
	assign intCool  = intTemp <= (`CFS_TSD_DEGC - `CFS_THYST_DEGC);
	assign extFault = ssDis && !s_ff.short2 && sgt(s_ff.extReading, s_ff.extFaultThr);
	assign extWarn  = ssDis && !s_ff.short2 && sgt(s_ff.extReading, s_ff.extWarnThr);
	assign extCool  = !sgt(s_ff.extReading, s_ff.extFaultThr - `CFS_EXT_HYST_DEGC);
	assign ocEvt    = (curSampleValid && sgt(calCur, s_ff.ocThr)) || s_ff.hsPk2; // see RULE2
	assign ocAny    = s_ff.ocSeen || ocEvt;
	assign ocTrip   = cycleStart && ocAny && s_ff.ocCnt == `CFS_OC_LAST_COUNT; // see RULE4
	assign ovTrip   = s_ff.ov2;
	assign uvTrip   = s_ff.state == cfs_pkg::ST_RUN && s_ff.uv2; // see RULE17
	assign tonTrip  = s_ff.state == cfs_pkg::ST_START && s_ff.uv2
		&& s_ff.msCnt >= s_ff.tonMax; // see RULE19
	assign anyFault = intHot || s_ff.intTrip || extFault || s_ff.extTrip || ovTrip
		|| uvTrip || tonTrip || ocTrip;
	assign alertSrc = {s_ff.vendStat[`CFS_VEND_INT_OT_BIT], s_ff.tempStat[`CFS_TEMP_WARN_BIT],
		s_ff.tempStat[`CFS_TEMP_FAULT_BIT], s_ff.convStat[3:0]};
	assign clrMask  = regWr ? regWrData : 16'h0000;

	always_comb begin
		nxt_s = s_ff;

		// ****************************************
		// pin synchronisers
		// ****************************************
		nxt_s.hsPk1  = hsPeakPin;
		nxt_s.hsPk2  = s_ff.hsPk1;
		nxt_s.ov1    = ovPin;
		nxt_s.ov2    = s_ff.ov1;
		nxt_s.uv1    = uvPin;
		nxt_s.uv2    = s_ff.uv1;
		nxt_s.short1 = extShortPin;
		nxt_s.short2 = s_ff.short1;
		nxt_s.rst1   = restartPin;
		nxt_s.rst2   = s_ff.rst1;

		// ****************************************
		// register writes
		// ****************************************
		if (regWr) begin
			case (regAddr)
				`CFS_REG_EXT_FAULT_THR: nxt_s.extFaultThr = regWrData; // see RULE10
				`CFS_REG_EXT_WARN_THR:  nxt_s.extWarnThr = regWrData; // see RULE10
				`CFS_REG_OPTIONS:       nxt_s.options = regWrData;
				`CFS_REG_RESPONSE_CFG:  nxt_s.respCfg = regWrData[7:0];
				`CFS_REG_ALERT_MASK:    nxt_s.alertMask = regWrData[7:0];
				`CFS_REG_MAX_TURN_ON:   nxt_s.tonMax = regWrData;
				`CFS_REG_CAL_OFFSET:    nxt_s.calOffset = regWrData;
				`CFS_REG_OC_FAULT_THR:  nxt_s.ocThr = regWrData;
				default: ;
			endcase
		end

		// ****************************************
		// sticky status, set wins over clear
		// ****************************************
		nxt_s.tempStat = s_ff.tempStat
			& ~((regAddr == `CFS_REG_TEMP_STATUS) ? clrMask[7:0] : 8'h00);
		nxt_s.vendStat = s_ff.vendStat
			& ~((regAddr == `CFS_REG_VENDOR_STATUS) ? clrMask[7:0] : 8'h00);
		nxt_s.convStat = s_ff.convStat
			& ~((regAddr == `CFS_REG_CONV_STATUS) ? clrMask[7:0] : 8'h00); // see RULE22
		nxt_s.tempStat[`CFS_TEMP_FAULT_BIT] = nxt_s.tempStat[`CFS_TEMP_FAULT_BIT]
			| extFault; // see RULE11
		nxt_s.tempStat[`CFS_TEMP_WARN_BIT] = nxt_s.tempStat[`CFS_TEMP_WARN_BIT]
			| extWarn; // see RULE11
		nxt_s.vendStat[`CFS_VEND_INT_OT_BIT] = nxt_s.vendStat[`CFS_VEND_INT_OT_BIT]
			| intHot; // see RULE8
		nxt_s.convStat[`CFS_CONV_OC_BIT] = nxt_s.convStat[`CFS_CONV_OC_BIT] | ocTrip;
		nxt_s.convStat[`CFS_CONV_OV_BIT] = nxt_s.convStat[`CFS_CONV_OV_BIT] | ovTrip;
		nxt_s.convStat[`CFS_CONV_UV_BIT] = nxt_s.convStat[`CFS_CONV_UV_BIT] | uvTrip;
		nxt_s.convStat[`CFS_CONV_TON_BIT] = nxt_s.convStat[`CFS_CONV_TON_BIT] | tonTrip;

		// ****************************************
		// external temperature reading
		// ****************************************
		if (!ssDis) begin
			nxt_s.extReading = `CFS_SS_MODE_DEGC; // see RULE13
		end else if (s_ff.short2) begin
			nxt_s.extReading = `CFS_SHORT_DEGC; // see RULE12
		end else begin
			nxt_s.extReading = extTempRaw; // see RULE10
		end

		// ****************************************
		// temperature trips with hysteresis
		// ****************************************
		if (intHot) begin
			nxt_s.intTrip = 1'b1; // see RULE8
		end else if (intCool) begin
			nxt_s.intTrip = 1'b0;
		end
		if (extFault && otResp != `CFS_RESP_IGNORE) begin
			nxt_s.extTrip = 1'b1; // see RULE9
		end else if (extCool) begin
			nxt_s.extTrip = 1'b0;
		end

		// ****************************************
		// overcurrent counting per switching cycle
		// ****************************************
		if (cycleStart) begin
			nxt_s.ocSeen = 1'b0;
			if (!ocAny) begin
				nxt_s.ocCnt = 2'h0; // see RULE21
			end else if (s_ff.ocCnt == `CFS_OC_LAST_COUNT) begin
				nxt_s.ocCnt = 2'h0;
			end else begin
				nxt_s.ocCnt = s_ff.ocCnt + 2'h1; // see RULE3
			end
		end else begin
			nxt_s.ocSeen = ocAny;
		end
		nxt_s.hsTrip = (cycleStart ? 1'b0 : s_ff.hsTrip) | s_ff.hsPk2; // see RULE7

		// ****************************************
		// converter state
		// ****************************************
		case (s_ff.state)
			cfs_pkg::ST_START: begin
				if (!s_ff.uv2) begin
					nxt_s.state = cfs_pkg::ST_RUN;
				end
			end
			cfs_pkg::ST_RUN: ;
			cfs_pkg::ST_HICCUP: begin
				if (s_ff.msCnt >= HICCUP_MS) begin
					nxt_s.state = cfs_pkg::ST_START; // see RULE5
				end
			end
			cfs_pkg::ST_LATCH: begin
				if (s_ff.rst2) begin
					nxt_s.state = cfs_pkg::ST_START; // see RULE17
				end
			end
			cfs_pkg::ST_COOL: begin
				if (!s_ff.intTrip && !s_ff.extTrip) begin
					nxt_s.state = cfs_pkg::ST_START;
				end
			end
			default: nxt_s.state = cfs_pkg::ST_START;
		endcase
		if (running) begin
			if (uvTrip || tonTrip) begin
				nxt_s.state = react(uvResp, cfs_pkg::ST_HICCUP, nxt_s.state); // see RULE18
			end
			if (ocTrip) begin
				nxt_s.state = react(ocResp, cfs_pkg::ST_HICCUP, nxt_s.state); // see RULE6
			end
			if (ovTrip) begin
				nxt_s.state = react(ovResp, cfs_pkg::ST_HICCUP, nxt_s.state); // see RULE16
			end
			if (extFault) begin
				nxt_s.state = react(otResp, cfs_pkg::ST_COOL, nxt_s.state); // see RULE14
			end
		end
		if (intHot && s_ff.state != cfs_pkg::ST_LATCH) begin
			nxt_s.state = cfs_pkg::ST_COOL; // see RULE8
		end

		// ****************************************
		// millisecond timer, restarted on each state change
		// ****************************************
		if (nxt_s.state != s_ff.state) begin
			nxt_s.msPre = 17'h0;
			nxt_s.msCnt = 16'h0;
		end else if (s_ff.msPre == MS_LAST) begin
			nxt_s.msPre = 17'h0;
			if (s_ff.msCnt != 16'hFFFF) begin
				nxt_s.msCnt = s_ff.msCnt + 16'h1;
			end
		end else begin
			nxt_s.msPre = s_ff.msPre + 17'h1;
		end

		// ****************************************
		// overvoltage discharge
		// ****************************************
		if (nxt_s.state == cfs_pkg::ST_START && s_ff.state != cfs_pkg::ST_START) begin
			nxt_s.ovDis = 1'b0;
		end
		if (ovTrip && ovResp != `CFS_RESP_IGNORE) begin
			nxt_s.ovDis = 1'b1; // see RULE15
		end

		// ****************************************
		// outputs
		// ****************************************
		nxt_s.hsGate = running && pwmHigh && !s_ff.hsTrip && !s_ff.hsPk2
			&& !s_ff.ovDis; // see RULE7
		nxt_s.lsGate = s_ff.ovDis || (running && pwmLow); // see RULE15
		nxt_s.pg = s_ff.state == cfs_pkg::ST_RUN && !anyFault; // see RULE20
		nxt_s.alert = |(alertSrc & ~s_ff.alertMask[6:0]); // see RULE22
		nxt_s.softStart = s_ff.state == cfs_pkg::ST_START;

		// ****************************************
		// register reads
		// ****************************************
		if (regRd) begin
			case (regAddr)
				`CFS_REG_EXT_FAULT_THR: nxt_s.rdData = s_ff.extFaultThr;
				`CFS_REG_EXT_WARN_THR:  nxt_s.rdData = s_ff.extWarnThr;
				`CFS_REG_TEMP_STATUS:   nxt_s.rdData = {8'h00, s_ff.tempStat};
				`CFS_REG_VENDOR_STATUS: nxt_s.rdData = {8'h00, s_ff.vendStat};
				`CFS_REG_EXT_READING:   nxt_s.rdData = s_ff.extReading;
				`CFS_REG_OPTIONS:       nxt_s.rdData = s_ff.options;
				`CFS_REG_CONV_STATUS:   nxt_s.rdData = {8'h00, s_ff.convStat};
				`CFS_REG_ALERT_MASK:    nxt_s.rdData = {8'h00, s_ff.alertMask};
				`CFS_REG_RESPONSE_CFG:  nxt_s.rdData = {8'h00, s_ff.respCfg};
				`CFS_REG_MAX_TURN_ON:   nxt_s.rdData = s_ff.tonMax;
				`CFS_REG_CAL_OFFSET:    nxt_s.rdData = s_ff.calOffset;
				`CFS_REG_CUR_TELEMETRY: nxt_s.rdData = curAvg; // see RULE1
				`CFS_REG_OC_FAULT_THR:  nxt_s.rdData = s_ff.ocThr;
				default:                nxt_s.rdData = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s_ff             <= '0;
			s_ff.state       <= cfs_pkg::ST_START;
			s_ff.extFaultThr <= `CFS_RST_EXT_FAULT_THR;
			s_ff.extWarnThr  <= `CFS_RST_EXT_WARN_THR;
			s_ff.options     <= `CFS_RST_OPTIONS;
			s_ff.respCfg     <= `CFS_RST_RESPONSE_CFG;
			s_ff.alertMask   <= `CFS_RST_ALERT_MASK;
			s_ff.tonMax      <= `CFS_RST_MAX_TURN_ON;
			s_ff.calOffset   <= `CFS_RST_CAL_OFFSET;
			s_ff.ocThr       <= `CFS_RST_OC_FAULT_THR;
		end else if (ce) begin
			s_ff <= nxt_s;
		end
	end

	assign regRdData    = s_ff.rdData;
	assign hsGateOn     = s_ff.hsGate;
	assign lsGateOn     = s_ff.lsGate;
	assign powerGoodOut = s_ff.pg;
	assign alertOut     = s_ff.alert;
	assign softStartOut = s_ff.softStart;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	sequence ovSeen;
		ce && ovTrip && ovResp != `CFS_RESP_IGNORE ##1 ce;
	endsequence
	sequence intSeen;
		ce && intHot && s_ff.state != cfs_pkg::ST_LATCH ##1 ce;
	endsequence

	a_peak_cut: assert property ( // see RULE7
		ce && s_ff.hsPk2 |=> !hsGateOn)
		else $error("high side on after peak trip");
	a_oc_count: assert property ( // see RULE3
		ce && cycleStart && ocAny && s_ff.ocCnt < `CFS_OC_LAST_COUNT
		|=> s_ff.ocCnt == $past(s_ff.ocCnt) + 2'h1)
		else $error("overcurrent count did not advance");
	a_oc_clear: assert property ( // see RULE21
		ce && cycleStart && !ocAny |=> s_ff.ocCnt == 2'h0)
		else $error("overcurrent count kept after clean cycle");
	a_oc_flag: assert property ( // see RULE4
		ce && cycleStart && ocAny && s_ff.ocCnt == `CFS_OC_LAST_COUNT
		|=> s_ff.convStat[`CFS_CONV_OC_BIT] && s_ff.ocCnt == 2'h0)
		else $error("third overcurrent not flagged");
	a_alert_or: assert property ( // see RULE22
		ce |=> alertOut == $past(|(alertSrc & ~s_ff.alertMask[6:0])))
		else $error("alert differs from unmasked flags");
	a_int_stop: assert property ( // see RULE8
		intSeen |=> !hsGateOn && s_ff.vendStat[`CFS_VEND_INT_OT_BIT])
		else $error("conversion not stopped on internal over-temperature");
	a_ext_short: assert property ( // see RULE12
		ce && ssDis && s_ff.short2 |=> s_ff.extReading == `CFS_SHORT_DEGC)
		else $error("shorted sensor not reading -40");
	a_ss_hold: assert property ( // see RULE13
		ce && !ssDis |=> s_ff.extReading == `CFS_SS_MODE_DEGC && !extFault)
		else $error("reading not held at 25 in soft-start mode");
	a_ov_drain: assert property ( // see RULE15
		ovSeen |=> lsGateOn && !hsGateOn)
		else $error("low side not discharging on overvoltage");
	a_pg_low: assert property ( // see RULE20
		ce && anyFault |=> !powerGoodOut)
		else $error("power good high during a fault");
	a_hiccup_wait: assert property ( // see RULE5
		ce && s_ff.state == cfs_pkg::ST_HICCUP && s_ff.msCnt < HICCUP_MS && !intHot
		|=> s_ff.state == cfs_pkg::ST_HICCUP)
		else $error("hiccup ended before seven soft-start periods");
endmodule

// ===== rtl/cfs_map.svh
// register map, field positions, reset values and timing of the fault supervisor
// Overview of operation
// RULE1: average digitized output current into telemetry
// RULE2: add calibration offset before telemetry and compare
// RULE3: count switching cycles with overcurrent events
// RULE4: three consecutive events flag, alert, then react
// RULE5: hiccup waits seven soft-starts, then retries
// RULE6: overcurrent ignore keeps peak limit only
// RULE7: high-side peak trip ends on-time at once
// RULE8: internal over 145C stops until 20C cooler
// RULE9: external fault stops until 20C below threshold
// RULE10: refresh 8Eh reading, thresholds at 4Fh, 51h
// RULE11: over-temperature sets 7Dh flags and alert
// RULE12: shorted sensor reads -40C, no external faults
// RULE13: soft-start pin mode holds reading at 25C
// RULE14: over-temperature response latch, restart or ignore
// RULE15: overvoltage discharges via low side, flags, reacts
// RULE16: overvoltage ignore keeps switching
// RULE17: undervoltage after start: FETs off, flag, react
// RULE18: undervoltage ignore keeps running
// RULE19: undervoltage detection waits maximum turn-on time
// RULE20: power good low on any fault
// RULE21: clean cycle clears overcurrent counter
// RULE22: flags sticky until cleared, alert ORs unmasked
`ifndef CFS_MAP_SVH
`define CFS_MAP_SVH

// ****************************************
// command codes
// ****************************************
`define CFS_REG_EXT_FAULT_THR  8'h4F
`define CFS_REG_EXT_WARN_THR   8'h51
`define CFS_REG_TEMP_STATUS    8'h7D
`define CFS_REG_VENDOR_STATUS  8'h80
`define CFS_REG_EXT_READING    8'h8E
`define CFS_REG_OPTIONS        8'hE5
`define CFS_REG_CONV_STATUS    8'hD0
`define CFS_REG_ALERT_MASK     8'hD1
`define CFS_REG_RESPONSE_CFG   8'hD2
`define CFS_REG_MAX_TURN_ON    8'hD3
`define CFS_REG_CAL_OFFSET     8'hD4
`define CFS_REG_CUR_TELEMETRY  8'hD5
`define CFS_REG_OC_FAULT_THR   8'hD6

// ****************************************
// fields
// ****************************************
`define CFS_OPT_SSDIS_BIT      0
`define CFS_TEMP_FAULT_BIT     7
`define CFS_TEMP_WARN_BIT      6
`define CFS_VEND_INT_OT_BIT    7
`define CFS_CONV_OC_BIT        0
`define CFS_CONV_OV_BIT        1
`define CFS_CONV_UV_BIT        2
`define CFS_CONV_TON_BIT       3
`define CFS_RESP_OC_LSB        0
`define CFS_RESP_OT_LSB        2
`define CFS_RESP_OV_LSB        4
`define CFS_RESP_UV_LSB        6
`define CFS_RESP_IGNORE        2'h0
`define CFS_RESP_LATCH         2'h1

// ****************************************
// reset values
// ****************************************
`define CFS_RST_EXT_FAULT_THR  16'h007D
`define CFS_RST_EXT_WARN_THR   16'h0064
`define CFS_RST_OPTIONS        16'h0000
`define CFS_RST_RESPONSE_CFG   8'hAA
`define CFS_RST_ALERT_MASK     8'h00
`define CFS_RST_MAX_TURN_ON    16'h000A
`define CFS_RST_CAL_OFFSET     16'h0000
`define CFS_RST_OC_FAULT_THR   16'h01F4

// ****************************************
// temperatures and timing
// ****************************************
`define CFS_TSD_DEGC           8'h91
`define CFS_THYST_DEGC         8'h14
`define CFS_EXT_HYST_DEGC      16'h0014
`define CFS_SHORT_DEGC         16'hFFD8
`define CFS_SS_MODE_DEGC       16'h0019
`define CFS_OC_LAST_COUNT      2'h2
`define CFS_HICCUP_PERIODS     7
`define CFS_CLK_MHZ            100
`define CFS_MS_TIME            1
`define CFS_MS_CYC             (`CFS_MS_TIME * `CFS_CLK_MHZ * 1000)
`define CFS_SS_TIME_MS         1

`endif

// ===== rtl/cfs_pkg.sv
// types of the converter fault supervisor
package cfs_pkg;

	typedef enum logic [2:0] {ST_START, ST_RUN, ST_HICCUP, ST_LATCH, ST_COOL} cfs_state_t;

	typedef struct packed {
		logic [18:0] acc;
		logic [2:0]  cnt;
		logic [15:0] avg;
	} cfs_avg_t;

	typedef struct packed {
		cfs_state_t  state;
		logic        hsPk1;
		logic        hsPk2;
		logic        ov1;
		logic        ov2;
		logic        uv1;
		logic        uv2;
		logic        short1;
		logic        short2;
		logic        rst1;
		logic        rst2;
		logic [15:0] extFaultThr;
		logic [15:0] extWarnThr;
		logic [15:0] options;
		logic [7:0]  respCfg;
		logic [7:0]  alertMask;
		logic [15:0] tonMax;
		logic [15:0] calOffset;
		logic [15:0] ocThr;
		logic [7:0]  tempStat;
		logic [7:0]  vendStat;
		logic [7:0]  convStat;
		logic [1:0]  ocCnt;
		logic        ocSeen;
		logic        hsTrip;
		logic        ovDis;
		logic        extTrip;
		logic        intTrip;
		logic [16:0] msPre;
		logic [15:0] msCnt;
		logic [15:0] extReading;
		logic        hsGate;
		logic        lsGate;
		logic        pg;
		logic        alert;
		logic        softStart;
		logic [15:0] rdData;
	} cfs_main_t;

endpackage

// ===== rtl/cfs_avg_filter.sv
// averaging filter for the calibrated current samples
`timescale 1ns/1ps
module cfs_avg_filter (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        ce,
	input  wire logic        sampleValid,
	input  wire logic [15:0] sample,
	output logic      [15:0] average
);
	cfs_pkg::cfs_avg_t s_ff;
	cfs_pkg::cfs_avg_t nxt_s;
	logic [18:0]       sum;

	function automatic logic [18:0] sext(input logic [15:0] v);
		return {{3{v[15]}}, v};
	endfunction

	assign sum = s_ff.acc + sext(sample);

	// ****************************************
	// eight samples summed, then divided by eight
	// ****************************************
	always_comb begin
		nxt_s = s_ff;
		if (sampleValid) begin
			nxt_s.cnt = s_ff.cnt + 3'h1;
			if (s_ff.cnt == 3'h7) begin // see RULE1
				nxt_s.acc = 19'h0;
				nxt_s.avg = sum[18:3];
			end else begin
				nxt_s.acc = sum;
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s_ff <= '0;
		end else if (ce) begin
			s_ff <= nxt_s;
		end
	end

	assign average = s_ff.avg;

	a_avg_dump: assert property (@(posedge clk) disable iff (reset) // see RULE1
		ce && sampleValid && s_ff.cnt == 3'h7 |=> average == $past(sum[18:3]))
		else $error("average not updated after eighth sample");
	a_avg_hold: assert property (@(posedge clk) disable iff (reset) // see RULE1
		!(ce && sampleValid && s_ff.cnt == 3'h7) |=> $stable(average))
		else $error("average changed between batches");
endmodule

// ===== verif/cfs_stage_model.sv
// power stage and sense comparator model facing the supervisor
`timescale 1ns/1ps
module cfs_stage_model (
	input  wire logic hsGateOn,
	input  wire logic peakReq,
	input  wire logic ovReq,
	input  wire logic uvReq,
	input  wire logic shortReq,
	output logic      hsPeakPin,
	output logic      ovPin,
	output logic      uvPin,
	output logic      extShortPin
);
	// ****************************************
	// comparators
	// ****************************************
	// peak sensed only while the high-side FET conducts
	assign hsPeakPin   = peakReq & hsGateOn;
	assign ovPin       = ovReq;
	assign uvPin       = uvReq;
	assign extShortPin = shortReq;
endmodule

// ===== verif/cfs_fault_supervisor_test.sv
// self-checking bench of the fault supervisor
`timescale 1ns/1ps
module cfs_fault_supervisor_test;
	logic clk = 1'h0, reset = 1'h1, cycleStart = 1'h0, curSampleValid = 1'h0;
	logic regWr = 1'h0, regRd = 1'h0, peakReq = 1'h0, shortReq = 1'h0;
	logic ovReq = 1'h0, uvReq = 1'h0, ce = 1'h1;
	logic [15:0] curSample = 16'h0000, extTempRaw = 16'h0000, regWrData = 16'h0000;
	logic [7:0]  regAddr = 8'h00, intTemp = 8'h19;
	logic [15:0] regRdData;
	logic        hsGateOn, lsGateOn, powerGoodOut, alertOut, softStartOut;
	logic        hsPeakPin, ovPin, uvPin, extShortPin;
	int          err_total = 0, checked = 0, n;
	always #5 clk = ~clk;
	cfs_stage_model i_cfs_stage_model (.hsGateOn(hsGateOn), .peakReq(peakReq), .ovReq(ovReq),
		.uvReq(uvReq), .shortReq(shortReq), .hsPeakPin(hsPeakPin), .ovPin(ovPin), .uvPin(uvPin),
		.extShortPin(extShortPin));
	cfs_fault_supervisor #(.MS_CYC(10), .SS_TIME_MS(1)) i_cfs_fault_supervisor (.clk(clk),
		.reset(reset), .ce(ce), .cycleStart(cycleStart), .pwmHigh(1'h1), .pwmLow(1'h0),
		.curSampleValid(curSampleValid), .curSample(curSample), .intTemp(intTemp),
		.extTempRaw(extTempRaw), .hsPeakPin(hsPeakPin), .ovPin(ovPin), .uvPin(uvPin),
		.extShortPin(extShortPin), .restartPin(1'h0), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
		.hsGateOn(hsGateOn), .lsGateOn(lsGateOn), .powerGoodOut(powerGoodOut),
		.alertOut(alertOut), .softStartOut(softStartOut));
	// ****************************************
	// shared tasks
	// ****************************************
	task results();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task chk(input string nm, input logic [15:0] e, input logic [15:0] s);
		checked++;
		if (s !== e) begin
			$display("ERROR %s expected %h seen %h", nm, e, s);
			err_total++;
		end
	endtask
	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		regAddr <= a; regWrData <= d; regWr <= 1'h1;
		@(posedge clk);
		regWr <= 1'h0;
	endtask
	task rdchk(input string nm, input logic [7:0] a, input logic [15:0] e);
		@(posedge clk);
		regAddr <= a; regRd <= 1'h1;
		@(posedge clk);
		regRd <= 1'h0;
		#1 chk(nm, e, regRdData);
	endtask
	task oc_cycle(input logic ev);
		@(posedge clk);
		peakReq <= ev;
		repeat (6) @(posedge clk);
		peakReq <= 1'h0;
		repeat (3) @(posedge clk);
		cycleStart <= 1'h1;
		@(posedge clk);
		cycleStart <= 1'h0;
		repeat (3) @(posedge clk);
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task t_reset_regs();
		rdchk("fault thr", 8'h4F, 16'h007D);
		rdchk("warn thr", 8'h51, 16'h0064);
		rdchk("responses", 8'hD2, 16'h00AA);
		rdchk("unmapped", 8'h10, 16'h0000);
		rdchk("ss mode reading", 8'h8E, 16'h0019);
		$display("done reset_regs");
	endtask
	task t_ext_reading();
		@(posedge clk);
		shortReq <= 1'h1; extTempRaw <= 16'h00C8;
		repeat (3) @(posedge clk);
		wr(8'hE5, 16'h0001);
		repeat (3) @(posedge clk);
		rdchk("short reading", 8'h8E, 16'hFFD8);
		rdchk("short no flags", 8'h7D, 16'h0000);
		shortReq <= 1'h0; extTempRaw <= 16'h001E;
		repeat (6) @(posedge clk);
		rdchk("raw reading", 8'h8E, 16'h001E);
		wr(8'h8E, 16'h1234);
		rdchk("read-only", 8'h8E, 16'h001E);
		$display("done ext_reading");
	endtask
	task t_average();
		wr(8'hD4, 16'h0002);
		repeat (8) begin
			@(posedge clk);
			curSampleValid <= 1'h1; curSample <= 16'h000A;
			@(posedge clk);
			curSampleValid <= 1'h0;
		end
		repeat (3) @(posedge clk);
		rdchk("telemetry", 8'hD5, 16'h000C);
		$display("done average");
	endtask
	task t_overcurrent();
		chk("hs on", 16'h0001, {15'h0000, hsGateOn});
		@(posedge clk);
		peakReq <= 1'h1;
		repeat (5) @(posedge clk);
		#1 chk("hs cut", 16'h0000, {15'h0000, hsGateOn});
		oc_cycle(1'h1);
		oc_cycle(1'h0);
		oc_cycle(1'h1);
		oc_cycle(1'h1);
		chk("no fault yet", 16'h0000, {15'h0000, alertOut});
		oc_cycle(1'h1);
		chk("oc alert", 16'h0001, {15'h0000, alertOut});
		chk("pg low", 16'h0000, {15'h0000, powerGoodOut});
		n = 0;
		while (softStartOut !== 1'h1 && n < 200) begin
			@(posedge clk);
			#1 n++;
		end
		chk("hiccup wait", 16'h0001, {15'h0000, n > 60 && n < 80});
		if (n == 200) results();
		rdchk("oc flag", 8'hD0, 16'h0001);
		wr(8'hD0, 16'h0001);
		repeat (2) @(posedge clk);
		#1 chk("alert cleared", 16'h0000, {15'h0000, alertOut});
		$display("done overcurrent");
	endtask
	task t_overtemp();
		@(posedge clk);
		extTempRaw <= 16'h00C8;
		repeat (8) @(posedge clk);
		rdchk("ot flags", 8'h7D, 16'h00C0);
		chk("ot alert", 16'h0001, {15'h0000, alertOut});
		chk("ot stop", 16'h0000, {15'h0000, hsGateOn});
		$display("done overtemp");
	endtask
	task t_overvoltage();
		@(posedge clk);
		extTempRaw <= 16'h001E;
		repeat (6) @(posedge clk);
		#1 chk("ot restart", 16'h0001, {15'h0000, hsGateOn});
		@(posedge clk);
		ovReq <= 1'h1;
		repeat (5) @(posedge clk);
		#1 chk("ov drain", 16'h0001, {15'h0000, lsGateOn & ~hsGateOn});
		@(posedge clk);
		ovReq <= 1'h0;
		rdchk("ov flag", 8'hD0, 16'h0002);
		wr(8'hD0, 16'h0002);
		$display("done overvoltage");
	endtask
	task t_int_ot();
		@(posedge clk);
		intTemp <= 8'h92;
		repeat (4) @(posedge clk);
		intTemp <= 8'h86;
		repeat (4) @(posedge clk);
		#1 chk("int ot hold", 16'h0000, {15'h0000, hsGateOn});
		rdchk("int ot flag", 8'h80, 16'h0080);
		@(posedge clk);
		intTemp <= 8'h7D;
		repeat (6) @(posedge clk);
		#1 chk("int ot restart", 16'h0001, {15'h0000, hsGateOn});
		$display("done int_ot");
	endtask
	task t_undervoltage();
		@(posedge clk);
		ce <= 1'h0;
		wr(8'hD3, 16'h0020);
		ce <= 1'h1;
		rdchk("ce freeze", 8'hD3, 16'h000A);
		@(posedge clk);
		uvReq <= 1'h1;
		repeat (5) @(posedge clk);
		#1 chk("uv fets off", 16'h0000, {15'h0000, hsGateOn | lsGateOn});
		rdchk("uv flag", 8'hD0, 16'h0004);
		wr(8'hD0, 16'h0004);
		repeat (200) @(posedge clk);
		rdchk("ton flag only", 8'hD0, 16'h0008);
		$display("done undervoltage");
	endtask
	initial begin
		repeat (20) @(posedge clk);
		reset <= 1'h0;
		repeat (20) @(posedge clk);
		t_reset_regs();
		t_ext_reading();
		t_average();
		t_overcurrent();
		t_overtemp();
		t_overvoltage();
		t_int_ot();
		t_undervoltage();
		results();
	end
endmodule
